// ===== rtl/rsel_defs.vh
// Constants for the receive status, replacement and loopback block
`ifndef RSEL_DEFS_VH
`define RSEL_DEFS_VH

// Register byte offsets (AXI4-Lite, one word each)
`define RSEL_OFS_CFG_A     8'h00
`define RSEL_OFS_DEEMPH_A  8'h04
`define RSEL_OFS_STAT_A    8'h08
`define RSEL_OFS_CFG_B     8'h10
`define RSEL_OFS_DEEMPH_B  8'h14
`define RSEL_OFS_STAT_B    8'h18
`define RSEL_OFS_GLOBAL    8'h20

// Channel configuration fields
`define RSEL_CFG_W         19
`define RSEL_CFG_RST       19'h00000
`define RSEL_CFG_DEC_EN    0
`define RSEL_CFG_COMMA_EN  1
`define RSEL_CFG_LOS_EN    2
`define RSEL_CFG_SYNC_EN   3
`define RSEL_CFG_PLL_EN    4
`define RSEL_CFG_DERR_EN   5
`define RSEL_CFG_RATE_EN   6
`define RSEL_CFG_GAIN_EN   7
`define RSEL_CFG_AZ_EN     8
`define RSEL_CFG_REP_LOS   9
`define RSEL_CFG_REP_SYNC  10
`define RSEL_CFG_REP_PLL   11
`define RSEL_CFG_REP_BRD   12
`define RSEL_CFG_REP_AZ    13
`define RSEL_CFG_REP_GAIN  14
`define RSEL_CFG_LOOP_LSB  16
`define RSEL_CFG_LOOP_MSB  18

// Loopback modes
`define RSEL_LOOP_OFF      3'h0
`define RSEL_LOOP_SHL_LOC  3'h1
`define RSEL_LOOP_DEEP_LOC 3'h2
`define RSEL_LOOP_DEEP_REM 3'h3
`define RSEL_LOOP_SHL_REM  3'h4

// De-emphasis pre/post-cursor field
`define RSEL_DEEMPH_W      9
`define RSEL_DEEMPH_RST    9'h000

// Global register
`define RSEL_GLB_BRD_EN    0
`define RSEL_GLB_RST       1'h0

// Status register fields
`define RSEL_STAT_W        8
`define RSEL_STAT_LOS      0
`define RSEL_STAT_OUT      1
`define RSEL_STAT_SYNC     2
`define RSEL_STAT_PLL      3
`define RSEL_STAT_DERR     4
`define RSEL_STAT_RATE     5
`define RSEL_STAT_GAIN     6
`define RSEL_STAT_AZ       7

// Replacement symbol K30.7: control 1, byte FE
`define RSEL_K30_7         9'h1FE

// AXI responses
`define RSEL_RESP_OKAY     2'h0
`define RSEL_RESP_SLVERR   2'h2

`endif

// ===== rtl/rsel_top.v
// Receive status combining, symbol replacement and loopback, two channels
`timescale 1ns/1ps
`include "rsel_defs.vh"

module rsel_chan (
  input  wire                      core_clk,
  input  wire                      srst,
  input  wire [`RSEL_CFG_W-1:0]    cfg,
  input  wire                      brd_los_en,
  input  wire                      board_status_input,
  input  wire                      los_det,
  input  wire                      sync_lost,
  input  wire                      pll_unlock,
  input  wire                      rate_sense_locked,
  input  wire                      gain_ctrl_locked,
  input  wire                      autozero_cal_done,
  input  wire [19:0]               tx_par_in,
  input  wire [19:0]               rx_deser_in,
  output reg  [19:0]               rx_par_out_reg,
  output reg  [19:0]               tx_ser_out_reg,
  output reg                       sig_loss_reg,
  output reg                       sync_allow_reg,
  output reg  [`RSEL_STAT_W-1:0]   stat_reg
);
  wire [2:0]  loop_mode;
  reg  [19:0] rx_src;
  reg  [19:0] rx_fix;
  reg  [19:0] tx_next;
  wire        dec_en;
  wire        comma_en;
  wire        dec_err;
  wire        sync_term;
  wire        opt_rep;
  wire        sig_loss_next;

  assign loop_mode = cfg[`RSEL_CFG_LOOP_MSB:`RSEL_CFG_LOOP_LSB];
  assign dec_en    = cfg[`RSEL_CFG_DEC_EN];
  assign comma_en  = cfg[`RSEL_CFG_COMMA_EN];

  // Receive source: serdes, or one of the two local loopback taps
  always @* begin
    if (loop_mode == `RSEL_LOOP_SHL_LOC) begin
      rx_src = tx_par_in;                              // [RULE_18]
    end else if (loop_mode == `RSEL_LOOP_DEEP_LOC) begin
      // Word already through the serializer stage comes back in
      rx_src = tx_ser_out_reg;                         // [RULE_19]
    end else begin
      rx_src = rx_deser_in;
    end
  end

  // Error flags exist only when the decoder fills bits 19 and 9
  assign dec_err = dec_en & (rx_src[19] | rx_src[9]);

  // Uncoded mode needs comma detection before sync loss may count
  assign sync_term = cfg[`RSEL_CFG_SYNC_EN] & sync_lost &
                     (dec_en | comma_en);              // [RULE_04] [RULE_05] [RULE_23]

  assign sig_loss_next =
      (cfg[`RSEL_CFG_LOS_EN] & los_det) |              // [RULE_01]
      (brd_los_en & ~board_status_input) |             // [RULE_03]
      sync_term |
      (cfg[`RSEL_CFG_PLL_EN] & pll_unlock) |           // [RULE_06]
      (cfg[`RSEL_CFG_DERR_EN] & dec_err) |             // [RULE_07]
      (cfg[`RSEL_CFG_RATE_EN] & ~rate_sense_locked) |  // [RULE_08]
      (cfg[`RSEL_CFG_GAIN_EN] & ~gain_ctrl_locked) |   // [RULE_09]
      (cfg[`RSEL_CFG_AZ_EN] & ~autozero_cal_done);     // [RULE_10] [RULE_11]

  assign opt_rep =
      (cfg[`RSEL_CFG_REP_LOS] & los_det) |             // [RULE_14]
      (cfg[`RSEL_CFG_REP_SYNC] & sync_lost) |          // [RULE_14]
      (cfg[`RSEL_CFG_REP_PLL] & pll_unlock) |          // [RULE_15]
      (cfg[`RSEL_CFG_REP_BRD] & ~board_status_input) | // [RULE_16]
      (cfg[`RSEL_CFG_REP_AZ] & ~autozero_cal_done) |   // [RULE_16]
      (cfg[`RSEL_CFG_REP_GAIN] & ~gain_ctrl_locked);   // [RULE_16]

  // Replacement; the error bit is kept so downstream still sees it
  always @* begin
    if (dec_en) begin
      rx_fix[19:10] = (opt_rep | rx_src[19]) ?
                      {rx_src[19], `RSEL_K30_7} :
                      rx_src[19:10];                   // [RULE_12] [RULE_13]
      rx_fix[9:0]   = (opt_rep | rx_src[9]) ?
                      {rx_src[9], `RSEL_K30_7} :
                      rx_src[9:0];                     // [RULE_12] [RULE_13]
    end else begin
      rx_fix = opt_rep ? 20'h00000 : rx_src;           // [RULE_13]
    end
  end

  // Transmit word: parallel input, or a remote loopback tap
  always @* begin
    if (loop_mode == `RSEL_LOOP_SHL_REM) begin
      tx_next = rx_fix;                                // [RULE_21]
    end else if (loop_mode == `RSEL_LOOP_DEEP_REM) begin
      tx_next = rx_par_out_reg;                        // [RULE_20]
    end else begin
      tx_next = tx_par_in;
    end
  end

  // All decisions are taken on the same edge as the data word
  always @(posedge core_clk) begin
    if (srst) begin
      rx_par_out_reg <= 20'h00000;
      tx_ser_out_reg <= 20'h00000;
      sig_loss_reg   <= 1'b0;
      sync_allow_reg <= 1'b0;
      stat_reg       <= 8'h00;
    end else begin
      rx_par_out_reg <= rx_fix;                        // [RULE_25]
      tx_ser_out_reg <= tx_next;
      sig_loss_reg   <= sig_loss_next;                 // [RULE_11] [RULE_25]
      sync_allow_reg <= ~(cfg[`RSEL_CFG_REP_LOS] & los_det); // [RULE_17]
      stat_reg[`RSEL_STAT_LOS]  <= los_det;            // [RULE_02]
      stat_reg[`RSEL_STAT_OUT]  <= sig_loss_next;
      stat_reg[`RSEL_STAT_SYNC] <= sync_lost;
      stat_reg[`RSEL_STAT_PLL]  <= pll_unlock;
      stat_reg[`RSEL_STAT_DERR] <= dec_err;
      stat_reg[`RSEL_STAT_RATE] <= rate_sense_locked;
      stat_reg[`RSEL_STAT_GAIN] <= gain_ctrl_locked;
      stat_reg[`RSEL_STAT_AZ]   <= autozero_cal_done;
    end
  end
endmodule

// How it works
// RULE_01 - Detector reaches output only when enabled
// RULE_02 - Signal-loss detector readable as status bit
// RULE_03 - Inverted board input ORed into both outputs
// RULE_04 - Sync loss ORed into output when enabled
// RULE_05 - Uncoded mode: sync term needs comma detection
// RULE_06 - PLL unlock ORed into output when enabled
// RULE_07 - Decode or disparity error ORed when enabled
// RULE_08 - Rate-sense unlocked ORed when enabled
// RULE_09 - Gain-control unlocked ORed when enabled
// RULE_10 - Auto-zero not done ORed when enabled
// RULE_11 - Output high while any enabled term active
// RULE_12 - Bad symbols always become K30.7 when decoding
// RULE_13 - Optional replacement: K30.7 or all zeros
// RULE_14 - Replace on signal loss or sync loss
// RULE_15 - Replace on PLL unlock when enabled
// RULE_16 - Replace on low board, auto-zero, gain flags
// RULE_17 - Sync blocked while loss replacement sees loss
// RULE_18 - Shallow local loopback skips the serdes
// RULE_19 - Deep local loopback goes through serdes
// RULE_20 - Deep remote loopback taps output register
// RULE_21 - Shallow remote loopback taps before register
// RULE_22 - Programmable pre/post-cursor de-emphasis field
// RULE_23 - Comma detection has its own enable
// RULE_24 - Channel B is an independent copy
// RULE_25 - Decisions registered with their data word
module rsel_top (
  input  wire                      core_clk,
  input  wire                      srst,
  input  wire [7:0]                s_axi_awaddr,
  input  wire                      s_axi_awvalid,
  output reg                       s_axi_awready,
  input  wire [31:0]               s_axi_wdata,
  input  wire [3:0]                s_axi_wstrb,
  input  wire                      s_axi_wvalid,
  output reg                       s_axi_wready,
  output reg  [1:0]                s_axi_bresp,
  output reg                       s_axi_bvalid,
  input  wire                      s_axi_bready,
  input  wire [7:0]                s_axi_araddr,
  input  wire                      s_axi_arvalid,
  output reg                       s_axi_arready,
  output reg  [31:0]               s_axi_rdata,
  output reg  [1:0]                s_axi_rresp,
  output reg                       s_axi_rvalid,
  input  wire                      s_axi_rready,
  input  wire                      board_status_input,
  input  wire                      los_det_ch_a,
  input  wire                      sync_lost_ch_a,
  input  wire                      pll_unlock_ch_a,
  input  wire                      rate_sense_locked_ch_a,
  input  wire                      gain_ctrl_locked_ch_a,
  input  wire                      autozero_cal_done_ch_a,
  input  wire [19:0]               tx_par_in_ch_a,
  input  wire [19:0]               rx_deser_in_ch_a,
  output wire [19:0]               rx_par_out_ch_a,
  output wire [19:0]               tx_ser_out_ch_a,
  output wire                      sig_loss_out_ch_a,
  output wire                      sync_allow_ch_a,
  output reg  [`RSEL_DEEMPH_W-1:0] deemph_ch_a,
  input  wire                      los_det_ch_b,
  input  wire                      sync_lost_ch_b,
  input  wire                      pll_unlock_ch_b,
  input  wire                      rate_sense_locked_ch_b,
  input  wire                      gain_ctrl_locked_ch_b,
  input  wire                      autozero_cal_done_ch_b,
  input  wire [19:0]               tx_par_in_ch_b,
  input  wire [19:0]               rx_deser_in_ch_b,
  output wire [19:0]               rx_par_out_ch_b,
  output wire [19:0]               tx_ser_out_ch_b,
  output wire                      sig_loss_out_ch_b,
  output wire                      sync_allow_ch_b,
  output reg  [`RSEL_DEEMPH_W-1:0] deemph_ch_b
);
  reg  [`RSEL_CFG_W-1:0]  cfg_a_reg;
  reg  [`RSEL_CFG_W-1:0]  cfg_b_reg;
  reg                     glb_reg;
  wire [`RSEL_STAT_W-1:0] stat_a;
  wire [`RSEL_STAT_W-1:0] stat_b;
  wire                    wr_go;
  wire                    rd_go;
  wire [31:0]             wmask;
  reg  [31:0]             rd_word;
  reg                     rd_hit;
  reg                     wr_hit;

  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

  // Address and data are taken together; one write outstanding
  assign wr_go = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
  assign rd_go = s_axi_arready & s_axi_arvalid;

  always @* begin
    wr_hit = 1'b1;
    if (s_axi_awaddr == `RSEL_OFS_CFG_A) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr == `RSEL_OFS_CFG_B) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr == `RSEL_OFS_DEEMPH_A) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr == `RSEL_OFS_DEEMPH_B) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr == `RSEL_OFS_GLOBAL) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr == `RSEL_OFS_STAT_A) begin
      wr_hit = 1'b1;
    end else if (s_axi_awaddr == `RSEL_OFS_STAT_B) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always @* begin
    rd_hit  = 1'b1;
    rd_word = 32'h00000000;
    if (s_axi_araddr == `RSEL_OFS_CFG_A) begin
      rd_word[`RSEL_CFG_W-1:0] = cfg_a_reg;
    end else if (s_axi_araddr == `RSEL_OFS_CFG_B) begin
      rd_word[`RSEL_CFG_W-1:0] = cfg_b_reg;
    end else if (s_axi_araddr == `RSEL_OFS_DEEMPH_A) begin
      rd_word[`RSEL_DEEMPH_W-1:0] = deemph_ch_a;
    end else if (s_axi_araddr == `RSEL_OFS_DEEMPH_B) begin
      rd_word[`RSEL_DEEMPH_W-1:0] = deemph_ch_b;
    end else if (s_axi_araddr == `RSEL_OFS_STAT_A) begin
      rd_word[`RSEL_STAT_W-1:0] = stat_a;              // [RULE_02]
    end else if (s_axi_araddr == `RSEL_OFS_STAT_B) begin
      rd_word[`RSEL_STAT_W-1:0] = stat_b;              // [RULE_02]
    end else if (s_axi_araddr == `RSEL_OFS_GLOBAL) begin
      rd_word[`RSEL_GLB_BRD_EN] = glb_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RSEL_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RSEL_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      cfg_a_reg     <= `RSEL_CFG_RST;                  // [RULE_01]
      cfg_b_reg     <= `RSEL_CFG_RST;
      deemph_ch_a   <= `RSEL_DEEMPH_RST;
      deemph_ch_b   <= `RSEL_DEEMPH_RST;
      glb_reg       <= `RSEL_GLB_RST;
    end else begin
      // Ready is a one-cycle pulse raised once both channels hold
      s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready &
                       ~s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready &
                       ~s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RSEL_RESP_OKAY : `RSEL_RESP_SLVERR;
        if (s_axi_awaddr == `RSEL_OFS_CFG_A) begin
          cfg_a_reg <= (cfg_a_reg & ~wmask[`RSEL_CFG_W-1:0]) |
                       (s_axi_wdata[`RSEL_CFG_W-1:0] &
                        wmask[`RSEL_CFG_W-1:0]);
        end else if (s_axi_awaddr == `RSEL_OFS_CFG_B) begin
          cfg_b_reg <= (cfg_b_reg & ~wmask[`RSEL_CFG_W-1:0]) |
                       (s_axi_wdata[`RSEL_CFG_W-1:0] &
                        wmask[`RSEL_CFG_W-1:0]);  // [RULE_24]
        end else if (s_axi_awaddr == `RSEL_OFS_DEEMPH_A) begin
          deemph_ch_a <= (deemph_ch_a & ~wmask[`RSEL_DEEMPH_W-1:0]) |
                         (s_axi_wdata[`RSEL_DEEMPH_W-1:0] &
                          wmask[`RSEL_DEEMPH_W-1:0]); // [RULE_22]
        end else if (s_axi_awaddr == `RSEL_OFS_DEEMPH_B) begin
          deemph_ch_b <= (deemph_ch_b & ~wmask[`RSEL_DEEMPH_W-1:0]) |
                         (s_axi_wdata[`RSEL_DEEMPH_W-1:0] &
                          wmask[`RSEL_DEEMPH_W-1:0]); // [RULE_22]
        end else if (s_axi_awaddr == `RSEL_OFS_GLOBAL) begin
          if (s_axi_wstrb[0]) begin
            glb_reg <= s_axi_wdata[`RSEL_GLB_BRD_EN];
          end
        end
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? `RSEL_RESP_OKAY : `RSEL_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  rsel_chan u_chan_a (
    .core_clk           (core_clk),
    .srst               (srst),
    .cfg                (cfg_a_reg),
    .brd_los_en         (glb_reg),
    .board_status_input (board_status_input),
    .los_det            (los_det_ch_a),
    .sync_lost          (sync_lost_ch_a),
    .pll_unlock         (pll_unlock_ch_a),
    .rate_sense_locked  (rate_sense_locked_ch_a),
    .gain_ctrl_locked   (gain_ctrl_locked_ch_a),
    .autozero_cal_done  (autozero_cal_done_ch_a),
    .tx_par_in          (tx_par_in_ch_a),
    .rx_deser_in        (rx_deser_in_ch_a),
    .rx_par_out_reg     (rx_par_out_ch_a),
    .tx_ser_out_reg     (tx_ser_out_ch_a),
    .sig_loss_reg       (sig_loss_out_ch_a),
    .sync_allow_reg     (sync_allow_ch_a),
    .stat_reg           (stat_a)
  );

  // Second channel: same logic with its own configuration word
  rsel_chan u_chan_b (
    .core_clk           (core_clk),
    .srst               (srst),
    .cfg                (cfg_b_reg),
    .brd_los_en         (glb_reg),
    .board_status_input (board_status_input),
    .los_det            (los_det_ch_b),
    .sync_lost          (sync_lost_ch_b),
    .pll_unlock         (pll_unlock_ch_b),
    .rate_sense_locked  (rate_sense_locked_ch_b),
    .gain_ctrl_locked   (gain_ctrl_locked_ch_b),
    .autozero_cal_done  (autozero_cal_done_ch_b),
    .tx_par_in          (tx_par_in_ch_b),
    .rx_deser_in        (rx_deser_in_ch_b),
    .rx_par_out_reg     (rx_par_out_ch_b),
    .tx_ser_out_reg     (tx_ser_out_ch_b),
    .sig_loss_reg       (sig_loss_out_ch_b),
    .sync_allow_reg     (sync_allow_ch_b),
    .stat_reg           (stat_b)
  );
endmodule

// ===== verification/rsel_top_sva.sv
// Assertion checker for the receive status, replacement and loopback block
`timescale 1ns/1ps
`include "rsel_defs.vh"
module rsel_top_sva (
  input wire        core_clk,
  input wire        srst,
  input wire [7:0]  s_axi_awaddr,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        los_det_ch_a,
  input wire        sync_lost_ch_a,
  input wire [19:0] tx_par_in_ch_a,
  input wire [19:0] rx_deser_in_ch_a,
  input wire [19:0] rx_par_out_ch_a,
  input wire        sig_loss_out_ch_a,
  input wire        sync_allow_ch_a,
  input wire        sig_loss_out_ch_b
);
  reg [18:0] cfg_a_reg;
  reg [18:0] cfg_b_reg;
  reg        glb_reg;
  // Shadow of the config words; only full-word writes are tracked
  always @(posedge core_clk) begin
    if (srst) begin
      cfg_a_reg <= 19'h00000;
      cfg_b_reg <= 19'h00000;
      glb_reg <= 1'h0;
    end else if (s_axi_awready && s_axi_wready && s_axi_wstrb == 4'hF) begin
      if (s_axi_awaddr == `RSEL_OFS_CFG_A) cfg_a_reg <= s_axi_wdata[18:0];
      if (s_axi_awaddr == `RSEL_OFS_CFG_B) cfg_b_reg <= s_axi_wdata[18:0];
      if (s_axi_awaddr == `RSEL_OFS_GLOBAL) glb_reg <= s_axi_wdata[0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  los_gate_a: assert property (
    cfg_a_reg == 19'h00004 && !glb_reg |=>
    sig_loss_out_ch_a == $past(los_det_ch_a)) else $error("loss gate wrong");
  sync_term_a: assert property (
    cfg_a_reg == 19'h0000A && !glb_reg |=>
    sig_loss_out_ch_a == $past(sync_lost_ch_a)) else $error("sync term wrong");
  quiet_out_a: assert property (
    cfg_a_reg == 19'h00000 && !glb_reg |=> !sig_loss_out_ch_a)
    else $error("loss output without cause");
  chb_quiet_a: assert property (
    cfg_b_reg == 19'h00000 && !glb_reg |=> !sig_loss_out_ch_b)
    else $error("channel b output without cause");
  bad_symbol_a: assert property (
    cfg_a_reg[0] && cfg_a_reg[18:16] == 3'h0 && rx_deser_in_ch_a[9] |=>
    rx_par_out_ch_a[8:0] == 9'h1FE) else $error("bad symbol kept");
  zero_fill_a: assert property (
    !cfg_a_reg[0] && cfg_a_reg[9] && cfg_a_reg[18:16] == 3'h0 &&
    los_det_ch_a |=> rx_par_out_ch_a == 20'h00000)
    else $error("word not zeroed");
  sync_block_a: assert property (
    cfg_a_reg[9] && los_det_ch_a |=> !sync_allow_ch_a)
    else $error("sync allowed during loss");
  shallow_loop_a: assert property (
    cfg_a_reg == 19'h10000 |=> rx_par_out_ch_a == $past(tx_par_in_ch_a))
    else $error("shallow local loop wrong");
  write_resp_a: assert property (
    s_axi_awready |=> s_axi_bvalid) else $error("write response missing");
endmodule

// ===== verification/rsel_serdes_model.sv
// Deserializer-side word source for one receive channel
`timescale 1ns/1ps
module rsel_serdes_model (
  input  wire        core_clk,
  input  wire        srst,
  input  wire        err_req,
  output wire [19:0] rx_word
);
  reg [17:0] pat_reg;
  // Word moves every cycle so a stale word never passes for a new one
  always @(posedge core_clk) begin
    if (srst)
      pat_reg <= 18'h2A5C3;
    else
      pat_reg <= {pat_reg[16:0], pat_reg[17] ^ pat_reg[10]};
  end
  // Error flags ride with their own symbol, as a decoder reports them
  assign rx_word = {err_req, pat_reg[17:9], err_req, pat_reg[8:0]};
endmodule

// ===== verification/rsel_top_bench.sv
// Self-checking bench for the receive status and loopback block
`timescale 1ns/1ps
module rsel_top_bench;
  logic        core_clk = 1'h0, srst = 1'h1, board = 1'h1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [1:0]  los = 2'h0, syncl = 2'h0, pll = 2'h0, err = 2'h0;
  logic [1:0]  rate = 2'h3, gain = 2'h3, az = 2'h3;
  logic [19:0] txp [2] = '{20'h0, 20'h0};
  wire         awready, wready, bvalid, arready, rvalid;
  wire [1:0]   bresp, rresp, sl, sa;
  wire [31:0]  rdata;
  wire [19:0]  rxw [2], rxo [2], txo [2];
  wire [8:0]   dm [2];
  int          bad_count = 0, samples_checked = 0;
  always #20 core_clk = ~core_clk;
  rsel_serdes_model far_a (.core_clk(core_clk), .srst(srst),
    .err_req(err[0]), .rx_word(rxw[0]));
  rsel_serdes_model far_b (.core_clk(core_clk), .srst(srst),
    .err_req(err[1]), .rx_word(rxw[1]));
  rsel_top dut (.core_clk(core_clk), .srst(srst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .board_status_input(board),
    .los_det_ch_a(los[0]), .sync_lost_ch_a(syncl[0]),
    .pll_unlock_ch_a(pll[0]), .rate_sense_locked_ch_a(rate[0]),
    .gain_ctrl_locked_ch_a(gain[0]), .autozero_cal_done_ch_a(az[0]),
    .tx_par_in_ch_a(txp[0]), .rx_deser_in_ch_a(rxw[0]),
    .rx_par_out_ch_a(rxo[0]), .tx_ser_out_ch_a(txo[0]),
    .sig_loss_out_ch_a(sl[0]), .sync_allow_ch_a(sa[0]), .deemph_ch_a(dm[0]),
    .los_det_ch_b(los[1]), .sync_lost_ch_b(syncl[1]),
    .pll_unlock_ch_b(pll[1]), .rate_sense_locked_ch_b(rate[1]),
    .gain_ctrl_locked_ch_b(gain[1]), .autozero_cal_done_ch_b(az[1]),
    .tx_par_in_ch_b(txp[1]), .rx_deser_in_ch_b(rxw[1]),
    .rx_par_out_ch_b(rxo[1]), .tx_ser_out_ch_b(txo[1]),
    .sig_loss_out_ch_b(sl[1]), .sync_allow_ch_b(sa[1]), .deemph_ch_b(dm[1]));

  task print_verdict;
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task lim(input int n);
    if (n >= 50) begin
      bad_count++;
      print_verdict;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (awready !== 1'h1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    while (bvalid !== 1'h1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    bready <= 1'h0;
    lim(n);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n = 0;
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (arready !== 1'h1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    arvalid <= 1'h0;
    while (rvalid !== 1'h1 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    lim(n);
  endtask
  // Drives one fault source of a channel to its bad or good level
  task fault(input int ch, input int i, input logic bad);
    case (i)
      0: los[ch] <= bad;
      1: syncl[ch] <= bad;
      2: pll[ch] <= bad;
      3: rate[ch] <= !bad;
      4: gain[ch] <= !bad;
      5: az[ch] <= !bad;
      6: board <= !bad;
      default: err[ch] <= bad;
    endcase
  endtask
  task settle;
    @(posedge core_clk);
    #1;
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(8'h00, d, r);
    chk(d, 32'h0);
    rd(8'h20, d, r);
    chk(d, 32'h0);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, d, r);
    chk(d, 32'h1FF);
    chk(dm[0], 32'h1FF);
    chk(dm[1], 32'h0);
    rd(8'h0C, d, r);
    chk(r, 32'h2);
    chk(d, 32'h0);
    wr(8'h0C, 32'h1);
    chk(bresp, 32'h2);
    $display("register test done");
  endtask
  task automatic t_status;
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'h20, 32'h1);
    fault(0, 6, 1'h1);
    settle;
    chk(sl, 32'h3);
    @(posedge core_clk);
    fault(0, 6, 1'h0);
    wr(8'h20, 32'h0);
    fault(0, 0, 1'h1);
    rd(8'h08, d, r);
    chk(d, 32'hE1);
    chk(sl, 32'h0);
    fault(0, 0, 1'h0);
    $display("status test done");
  endtask
  task automatic t_terms(input int ch);
    logic [18:0] en [8] = '{19'h4, 19'hA, 19'h10, 19'h40, 19'h80, 19'h100,
                            19'h8, 19'h21};
    int fi [8] = '{0, 1, 2, 3, 4, 5, 1, 7};
    logic [31:0] d;
    logic [1:0]  r;
    for (int k = 0; k < 8; k++) begin
      wr(ch ? 8'h10 : 8'h00, {13'h0, en[k]});
      fault(ch, fi[k], 1'h1);
      settle;
      chk(sl, (k == 6) ? 32'h0 : 32'h1 << ch);
      if (k == 7)
        chk(rxo[ch], 32'hFFBFE);
      if (k == 0) begin
        rd(ch ? 8'h18 : 8'h08, d, r);
        chk(d, 32'hE3);
      end
      @(posedge core_clk);
      fault(ch, fi[k], 1'h0);
      settle;
      chk(sl, 32'h0);
    end
    wr(ch ? 8'h10 : 8'h00, 32'h0);
    $display("status terms test done on channel %0d", ch);
  endtask
  task automatic t_replace;
    logic [19:0] w;
    logic [18:0] rep [5] = '{19'h200, 19'h400, 19'h1000, 19'h2000, 19'h4000};
    int fi [5] = '{0, 1, 6, 5, 4};
    wr(8'h00, 32'h1);
    fault(0, 7, 1'h1);
    settle;
    chk(rxo[0], 32'hFFBFE);
    @(posedge core_clk);
    fault(0, 7, 1'h0);
    settle;
    w = rxw[0];
    settle;
    chk(rxo[0], w);
    wr(8'h00, 32'h801);
    fault(0, 2, 1'h1);
    settle;
    chk(rxo[0], 32'h7F9FE);
    @(posedge core_clk);
    fault(0, 2, 1'h0);
    for (int k = 0; k < 5; k++) begin
      wr(8'h00, {13'h0, rep[k]});
      fault(0, fi[k], 1'h1);
      settle;
      chk(rxo[0], 32'h0);
      @(posedge core_clk);
      fault(0, fi[k], 1'h0);
    end
    wr(8'h00, 32'h200);
    fault(0, 0, 1'h1);
    settle;
    chk(sa, 32'h2);
    @(posedge core_clk);
    fault(0, 0, 1'h0);
    settle;
    chk(sa, 32'h3);
    $display("replacement test done");
  endtask
  task automatic t_loop;
    logic [19:0] w;
    txp[0] <= 20'hA5A5A;
    txp[1] <= 20'hC3C3C;
    wr(8'h00, 32'h10000);
    txp[0] <= 20'h3C3C3;
    settle;
    chk(rxo[0], 32'h3C3C3);
    chk(txo[1], 32'hC3C3C);
    wr(8'h00, 32'h20000);
    txp[0] <= 20'h5A5A5;
    settle;
    chk(rxo[0], 32'h3C3C3);
    settle;
    chk(rxo[0], 32'h5A5A5);
    wr(8'h00, 32'h40000);
    settle;
    w = rxw[0];
    settle;
    chk(txo[0], w);
    wr(8'h00, 32'h30000);
    settle;
    w = rxw[0];
    settle;
    settle;
    chk(txo[0], w);
    wr(8'h00, 32'h0);
    $display("loopback test done");
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    srst <= 1'h0;
    t_regs;
    t_status;
    t_terms(0);
    t_terms(1);
    t_replace;
    t_loop;
    print_verdict;
  end
endmodule

bind rsel_top rsel_top_sva u_sva (.core_clk(core_clk), .srst(srst),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .los_det_ch_a(los_det_ch_a), .sync_lost_ch_a(sync_lost_ch_a),
  .tx_par_in_ch_a(tx_par_in_ch_a), .rx_deser_in_ch_a(rx_deser_in_ch_a),
  .rx_par_out_ch_a(rx_par_out_ch_a), .sig_loss_out_ch_a(sig_loss_out_ch_a),
  .sync_allow_ch_a(sync_allow_ch_a), .sig_loss_out_ch_b(sig_loss_out_ch_b));
